/* File: inc/cdc_pkg.sv */
`default_nettype none
package cdc_pkg;
	// register map
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	// field positions of the control register
	localparam int RECOVER_BIT = 15;
	localparam int RATIO_LSB = 12;
	localparam int ENABLE_BIT = 11;
	localparam int RCPOST_LSB = 8;
	localparam int OUTDIV_LSB = 6;
	localparam int PRESCALE_LSB = 0;
	// values after reset, the reserved output divider code and the no-reduction ratio code
	localparam logic [15:0] CTRL_RESET = 16'h3040;
	localparam logic [2:0] RATIO_RESET = 3'h3;
	localparam logic [1:0] OUTDIV_RESET = 2'h1;
	localparam logic [1:0] OUTDIV_RESERVED = 2'h2;
	localparam logic [2:0] RATIO_NONE = 3'h0;
	// counter width of the processor tick divider
	localparam int RATIO_CNT_W = 7;

	typedef struct packed {
		logic interrupt_recovery;
		logic [2:0] cpu_clock_reduction_ratio;
		logic reduce_ratio_enable;
		logic [2:0] rc_osc_postscale;
		logic [1:0] pll_output_divider;
		logic unused_bit5;
		logic [4:0] pll_input_prescaler;
	} cdc_ctrl_type;
endpackage : cdc_pkg
`default_nettype wire

/* File: hw/cdc_cpu_tick.sv */
`timescale 1ns/1ps
`default_nettype none
// issues one processor-clock tick per 2**ratio peripheral-clock cycles
module cdc_cpu_tick #(
	parameter int CNT_W = 7
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // async reset, high
	input wire logic enable_i, // reduction active
	input wire logic [2:0] ratio_i, // exponent of the division
	output logic tick_o // one cycle per processor clock
);
	// ratio 7 needs a count up to 127
	if (CNT_W < 7) begin : g_bad_width
		$error("counter too narrow for ratio 128");
	end
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] limit;

	always_comb begin
		limit = CNT_W'((1 << ratio_i) - 1);
		next_count = '0;
		if (enable_i && count < limit) begin
			next_count = count + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// equal rates when reduction off
	assign tick_o = !enable_i || count == limit;
endmodule : cdc_cpu_tick
`default_nettype wire

/* File: hw/cdc_clock_divisor.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - with recovery set, any interrupt clears the reduce-ratio enable.
// - software cannot set the enable in a write that leaves the ratio field at 000.
// - ratio field writes are dropped while the enable is set.
// - the ratio field at bits 14-12 divides the processor clock by 2**code, reset code 3 (8).
// - the output divider at bits 7-6 resets to divide-by-4 and code 10 is refused.
module cdc_clock_divisor (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // async reset, high
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic irq_event_i, // any interrupt, same clock
	output logic cpu_tick_o, // processor clock enable tick
	output logic [2:0] rc_postscale_o, // rc oscillator postscaler code
	output logic [1:0] pll_post_o, // pll output divider code
	output logic [4:0] pll_pre_o // pll input prescaler code
);
	cdc_pkg::cdc_ctrl_type ctrl;
	cdc_pkg::cdc_ctrl_type next_ctrl;
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [3:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic do_write, wr_ctrl;
	logic [15:0] wr_val;
	logic tick;

	////////////////////////////////////////////////////////////////////////
	// bus slave
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr[3:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		do_write = next_aw_held && next_w_held && !s_axi_bvalid;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
		end
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		wr_ctrl = 1'b0;
		if (do_write) begin
			next_bvalid = 1'b1;
			wr_ctrl = next_aw_addr == cdc_pkg::CTRL_OFFSET;
			next_bresp = (wr_ctrl || next_aw_addr == cdc_pkg::STATUS_OFFSET) ? 2'h0 : 2'h2;
		end
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = 2'h0;
			unique case (s_axi_araddr[3:0])
				cdc_pkg::CTRL_OFFSET: next_rdata = {16'h0000, ctrl};
				cdc_pkg::STATUS_OFFSET: next_rdata = {31'h0000_0000, tick};
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = 2'h2;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register
	always_comb begin
		wr_val[7:0] = next_w_strb[0] ? next_w_data[7:0] : ctrl[7:0];
		wr_val[15:8] = next_w_strb[1] ? next_w_data[15:8] : ctrl[15:8];
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = wr_val;
			next_ctrl.unused_bit5 = 1'b0;
			// ratio frozen while reduction on
			if (ctrl.reduce_ratio_enable) begin
				next_ctrl.cpu_clock_reduction_ratio = ctrl.cpu_clock_reduction_ratio;
			end
			// enable cannot rise with ratio 000
			if (next_ctrl.cpu_clock_reduction_ratio == cdc_pkg::RATIO_NONE
					&& !ctrl.reduce_ratio_enable) begin
				next_ctrl.reduce_ratio_enable = 1'b0;
			end
			if (wr_val[cdc_pkg::OUTDIV_LSB +: 2] == cdc_pkg::OUTDIV_RESERVED) begin
				next_ctrl.pll_output_divider = ctrl.pll_output_divider;
			end
		end
		// interrupt wins over software
		if (ctrl.interrupt_recovery && irq_event_i) begin
			next_ctrl.reduce_ratio_enable = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= cdc_pkg::CTRL_RESET;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			ctrl <= next_ctrl;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// processor clock divider
	cdc_cpu_tick #(.CNT_W(cdc_pkg::RATIO_CNT_W)) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(ctrl.reduce_ratio_enable),
		.ratio_i(ctrl.cpu_clock_reduction_ratio),
		.tick_o(tick)
	);

	assign cpu_tick_o = tick;
	assign rc_postscale_o = ctrl.rc_osc_postscale;
	assign pll_post_o = ctrl.pll_output_divider;
	assign pll_pre_o = ctrl.pll_input_prescaler;

	////////////////////////////////////////////////////////////////////////
	// checks
	irq_recovery_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.interrupt_recovery && irq_event_i |=> !ctrl.reduce_ratio_enable)
		else $error("enable survived a recovering interrupt");
	irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl.interrupt_recovery && !wr_ctrl |=> $stable(ctrl.reduce_ratio_enable))
		else $error("enable moved without write or recovery");
	zero_ratio_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.reduce_ratio_enable |-> ctrl.cpu_clock_reduction_ratio != 3'h0)
		else $error("enable set with ratio zero");
	zero_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && !ctrl.reduce_ratio_enable
		&& wr_val[cdc_pkg::RATIO_LSB +: 3] == cdc_pkg::RATIO_NONE
		|=> !ctrl.reduce_ratio_enable)
		else $error("enable rose with ratio zero");
	ratio_frozen_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.reduce_ratio_enable |=> $stable(ctrl.cpu_clock_reduction_ratio))
		else $error("ratio changed while enabled");
	ratio_taken_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && !ctrl.reduce_ratio_enable
		|=> ctrl.cpu_clock_reduction_ratio == $past(wr_val[cdc_pkg::RATIO_LSB +: 3]))
		else $error("ratio write lost while disabled");
	no_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.pll_output_divider != 2'h2)
		else $error("reserved output divider held");
	outdiv_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && wr_val[cdc_pkg::OUTDIV_LSB +: 2] == cdc_pkg::OUTDIV_RESERVED
		|=> $stable(ctrl.pll_output_divider))
		else $error("reserved output divider taken");
	full_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl.reduce_ratio_enable |-> tick)
		else $error("tick missing at full rate");
	div_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.reduce_ratio_enable && ctrl.cpu_clock_reduction_ratio == 3'h1 && tick
		##1 ctrl.reduce_ratio_enable && $stable(ctrl.cpu_clock_reduction_ratio)
		|-> !tick ##1 tick)
		else $error("divide by two wrong spacing");
	// ratio is never zero while enabled, so ticks never touch
	tick_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.reduce_ratio_enable && tick ##1 ctrl.reduce_ratio_enable |-> !tick)
		else $error("back to back ticks while reduced");

	// bus answers
	write_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		do_write |=> s_axi_bvalid)
		else $error("write response missing");
	read_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	bresp_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule : cdc_clock_divisor
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid, irq = 1'b0, tick;
	logic [1:0] bresp, rresp, pll_post;
	logic [2:0] rc_post;
	logic [4:0] pll_pre;
	logic [31:0] got;
	logic [1:0] resp;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	cdc_clock_divisor dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq_event_i(irq), .cpu_tick_o(tick),
		.rc_postscale_o(rc_post), .pll_post_o(pll_post), .pll_pre_o(pll_pre));
	always #2.5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (bad_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	////////////////////////////////////////////////////////////////
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tk;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk_i);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tk = bvalid;
			resp = bresp;
			@(posedge clk_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tk) bready <= 1'b0;
		end while (!tk);
		check("bresp", {30'h0, resp}, {30'h0, er});
	endtask : axi_write
	task automatic axi_read(input logic [31:0] a);
		logic ta, tr;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk_i);
			ta = arvalid && arready;
			tr = rvalid;
			got = rdata;
			resp = rresp;
			@(posedge clk_i);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end while (!tr);
	endtask : axi_read
	task automatic pulse_irq;
		@(posedge clk_i);
		irq <= 1'b1;
		@(posedge clk_i);
		irq <= 1'b0;
	endtask : pulse_irq
	task automatic ctrl_is(input logic [31:0] exp);
		axi_read({28'h000_0000, cdc_pkg::CTRL_OFFSET});
		check("control", got, exp);
	endtask : ctrl_is
	task automatic count_ticks(input int cyc);
		n = 0;
		repeat (cyc) begin
			@(negedge clk_i);
			if (tick === 1'b1) n++;
		end
	endtask : count_ticks
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		ctrl_is({16'h0000, cdc_pkg::CTRL_RESET});
		check("pll post", {30'h0, pll_post}, {30'h0, cdc_pkg::OUTDIV_RESET});
		count_ticks(16);
		check("ticks idle", n, 16);
		axi_read({28'h000_0000, cdc_pkg::STATUS_OFFSET});
		check("status tick", got, 32'h0000_0001);
		axi_write(32'h0000_0000, 32'h0000_0800, 2'h0);
		ctrl_is(32'h0000_0000);
		axi_write(32'h0000_0000, 32'h0000_07FF, 2'h0);
		ctrl_is(32'h0000_07DF);
		check("rc post", {29'h0, rc_post}, 32'h0000_0007);
		check("pll post set", {30'h0, pll_post}, 32'h0000_0003);
		check("pll pre", {27'h0, pll_pre}, 32'h0000_001F);
		axi_write(32'h0000_0000, 32'h0000_0080, 2'h0);
		ctrl_is(32'h0000_00C0);
		check("pll post kept", {30'h0, pll_post}, 32'h0000_0003);
		axi_write(32'h0000_0000, 32'h0000_1800, 2'h0);
		ctrl_is(32'h0000_1800);
		count_ticks(16);
		check("ticks ratio 1", n, 8);
		axi_write(32'h0000_0000, 32'h0000_7800, 2'h0);
		ctrl_is(32'h0000_1800);
		axi_write(32'h0000_0000, 32'h0000_9800, 2'h0);
		ctrl_is(32'h0000_9800);
		pulse_irq();
		ctrl_is(32'h0000_9000);
		count_ticks(16);
		check("ticks recovered", n, 16);
		axi_write(32'h0000_0000, 32'h0000_7800, 2'h0);
		ctrl_is(32'h0000_7800);
		pulse_irq();
		ctrl_is(32'h0000_7800);
		count_ticks(256);
		check("ticks ratio 7", n, 2);
		for (int r = 1; r < 8; r++) begin
			axi_write(32'h0000_0000, 32'h0000_0000, 2'h0);
			axi_write(32'h0000_0000, 32'h0000_0800 | (r << 12), 2'h0);
			count_ticks(256);
			check("ticks per ratio", n, 256 >> r);
		end
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		ctrl_is({16'h0000, cdc_pkg::CTRL_RESET});
		count_ticks(16);
		check("ticks after reset", n, 16);
		axi_read(32'h0000_0008);
		check("unmapped resp", {30'h0, resp}, 32'h0000_0002);
		check("unmapped data", got, 32'h0000_0000);
		axi_write(32'h0000_0008, 32'h0000_0800, 2'h2);
		ctrl_is({16'h0000, cdc_pkg::CTRL_RESET});
		complete_run();
	end
endmodule : tb
`default_nettype wire
